// ===== hw/epc_counter.sv
// Encoder position counter with index latch and register port
`timescale 1ns/1ps
`default_nettype none

// Function
// - Position is signed 32 bits, readable, writable, reset to zero.
// - Step factor is signed with 16 integer and 16 fractional bits.
// - Each count adds or subtracts the factor; fraction binary 1/65536 or decimal 1/10000.
// - Step factor resets to 0x10000, meaning exactly one.
// - Index flag bit 0 reads one after an index event, zero otherwise.
// - Writing one to flag bit 0 clears it unless an index event sets it in the same cycle; writing zero leaves it.
// - Read-only latch captures position on index event; resets to zero.
// - Index needs N polarity and A/B polarities unless quadrature is ignored.
// - Sensitivity selects level, active edge, inactive edge or both edges.
// - Clear-on-index zeroes position at the same event that latches it.
// - Continuous acts on every event; once acts on first event after write.
module epc_counter (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_enc_a,
  input wire logic i_enc_b,
  input wire logic i_enc_n,
  input wire logic [6:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  input wire logic i_mode_wr,
  input wire logic i_mode_pol_a,
  input wire logic i_mode_pol_b,
  input wire logic i_mode_pol_n,
  input wire logic i_mode_index_ignore_quadrature,
  input wire logic i_mode_latch_cont,
  input wire logic i_mode_latch_once,
  input wire logic [1:0] i_mode_index_sens,
  input wire logic i_mode_clear_on_index,
  input wire logic i_mode_sel_decimal
);

  // ********************************
  // Pin synchronisers
  // ********************************
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] prev_r;
  logic [2:0] warm_r;
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      prev_r <= 3'h0;
      warm_r <= 3'h0;
    end else begin
      sync1_r <= {i_enc_n, i_enc_b, i_enc_a};
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      warm_r <= {warm_r[1:0], 1'b1};
    end
  end

  // Reset zeroes the pipeline, not the pins: no count or index until prev_r is a real sample
  wire primed = warm_r[2];

  wire a_now = sync2_r[0];
  wire b_now = sync2_r[1];
  wire step_valid = primed & ((a_now ^ prev_r[0]) ^ (b_now ^ prev_r[1]));
  wire step_up = prev_r[0] ^ b_now;

  // ********************************
  // Index detection
  // ********************************
  // polarity match
  wire ab_match = i_mode_index_ignore_quadrature |
                  ((a_now == i_mode_pol_a) & (b_now == i_mode_pol_b));
  wire idx_active = (sync2_r[2] == i_mode_pol_n) & ab_match;
  wire prev_ab = i_mode_index_ignore_quadrature |
                 ((prev_r[0] == i_mode_pol_a) & (prev_r[1] == i_mode_pol_b));
  wire idx_prev = (prev_r[2] == i_mode_pol_n) & prev_ab;
  logic index_raw;
  always_comb begin
    case (i_mode_index_sens)
      epc_pkg::SENS_LEVEL: index_raw = idx_active;
      epc_pkg::SENS_TO_ACTIVE: index_raw = idx_active & ~idx_prev;
      epc_pkg::SENS_TO_INACTIVE: index_raw = ~idx_active & idx_prev;
      epc_pkg::SENS_BOTH: index_raw = idx_active ^ idx_prev;
      default: index_raw = 1'b0;
    endcase
  end
  wire index_evt = primed & index_raw;

  // ********************************
  // Register decode
  // ********************************
  wire wr_pos = i_reg_wr & (i_reg_addr == epc_pkg::OFS_POSITION);
  wire wr_fac = i_reg_wr & (i_reg_addr == epc_pkg::OFS_STEP_FACTOR);
  wire wr_flag = i_reg_wr & (i_reg_addr == epc_pkg::OFS_FLAGS);

  logic [31:0] pos_r;
  logic [15:0] frac_r;
  logic [31:0] factor_r;
  logic [31:0] latch_r;
  logic flag_r;
  logic once_armed_r;

  wire latch_do = index_evt & (i_mode_latch_cont | once_armed_r);

  // ********************************
  // Step arithmetic
  // ********************************
  // Magnitude form lets both scalings share one borrow/carry path
  wire fac_neg = factor_r[31];
  wire [31:0] fac_mag = fac_neg ? (32'h0 - factor_r) : factor_r;
  wire [16:0] modulus = i_mode_sel_decimal ? epc_pkg::MOD_DECIMAL : epc_pkg::MOD_BINARY;
  wire go_up = step_up ^ fac_neg;
  wire [16:0] frac_sum = {1'b0, frac_r} + {1'b0, fac_mag[15:0]};
  wire [16:0] frac_dif = {1'b0, frac_r} - {1'b0, fac_mag[15:0]};
  wire carry = frac_sum >= modulus;
  wire borrow = frac_dif[16];
  wire [16:0] frac_up = carry ? (frac_sum - modulus) : frac_sum;
  wire [16:0] frac_dn = borrow ? (frac_dif + modulus) : frac_dif;
  wire [31:0] int_mag = {16'h0, fac_mag[31:16]};
  wire [31:0] pos_up = pos_r + int_mag + {31'h0, carry};
  wire [31:0] pos_dn = pos_r - int_mag - {31'h0, borrow};

  logic [31:0] pos_nxt;
  logic [15:0] frac_nxt;
  always_comb begin
    pos_nxt = pos_r;
    frac_nxt = frac_r;
    if (step_valid) begin
      pos_nxt = go_up ? pos_up : pos_dn;
      frac_nxt = go_up ? frac_up[15:0] : frac_dn[15:0];
    end
    if (latch_do && i_mode_clear_on_index) begin
      pos_nxt = epc_pkg::RST_POSITION;
      frac_nxt = 16'h0;
    end
    if (wr_pos) begin
      pos_nxt = i_reg_wdata;
      frac_nxt = 16'h0;
    end
  end

  // ********************************
  // State registers
  // ********************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      pos_r <= epc_pkg::RST_POSITION;
      frac_r <= 16'h0;
      factor_r <= epc_pkg::RST_STEP_FACTOR;
    end else begin
      pos_r <= pos_nxt;
      frac_r <= frac_nxt;
      if (wr_fac) begin
        factor_r <= i_reg_wdata;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      latch_r <= epc_pkg::RST_LATCH;
      flag_r <= epc_pkg::RST_FLAG;
      once_armed_r <= 1'b0;
    end else begin
      if (latch_do) begin
        latch_r <= pos_r;
      end
      if (index_evt) begin
        flag_r <= 1'b1;
      end else if (wr_flag && i_reg_wdata[epc_pkg::FLAG_INDEX_BIT]) begin
        flag_r <= 1'b0;
      end
      if (i_mode_wr) begin
        once_armed_r <= i_mode_latch_once;
      end else if (latch_do) begin
        once_armed_r <= 1'b0;
      end
    end
  end

  // ********************************
  // Read port
  // ********************************
  logic [31:0] rd_mux;
  always_comb begin
    case (i_reg_addr)
      epc_pkg::OFS_POSITION: rd_mux = pos_r;
      epc_pkg::OFS_STEP_FACTOR: rd_mux = factor_r;
      epc_pkg::OFS_FLAGS: rd_mux = {31'h0, flag_r};
      epc_pkg::OFS_LATCH: rd_mux = latch_r;
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_reg_rdata <= 32'h0;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rd_mux;
    end
  end

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  sequence s_evt_no_clr;
    index_evt ##0 !wr_pos;
  endsequence

  reset_values_a: assert property ($rose(i_resetn) |-> pos_r == 32'h0
    && factor_r == 32'h0001_0000 && latch_r == 32'h0 && !flag_r)
    else $error("bad reset values");
  factor_store_a: assert property (wr_fac |=> factor_r == $past(i_reg_wdata))
    else $error("factor not stored");
  binary_step_a: assert property (step_valid && !i_mode_sel_decimal && !wr_pos
    && !latch_do |=> {pos_r, frac_r} == $past({pos_r, frac_r})
    + ($past(step_up) ? {{16{$past(factor_r[31])}}, $past(factor_r)}
    : -{{16{$past(factor_r[31])}}, $past(factor_r)}))
    else $error("binary step wrong");
  flag_set_a: assert property (index_evt |=> flag_r)
    else $error("flag not set");
  flag_clear_a: assert property (wr_flag && i_reg_wdata[0] && !index_evt |=> !flag_r)
    else $error("flag not cleared");
  flag_hold_a: assert property (flag_r && !(wr_flag && i_reg_wdata[0]) |=> flag_r)
    else $error("flag lost");
  latch_capture_a: assert property (latch_do |=> latch_r == $past(pos_r))
    else $error("latch wrong");
  index_clear_a: assert property (s_evt_no_clr ##0 (latch_do && i_mode_clear_on_index)
    |=> pos_r == 32'h0 && frac_r == 16'h0)
    else $error("position not cleared");
  once_drop_a: assert property (latch_do && !i_mode_wr |=> !once_armed_r)
    else $error("one-shot stayed armed");
  no_event_a: assert property (!index_evt && !wr_flag |=> flag_r == $past(flag_r))
    else $error("flag moved without event");

endmodule

`default_nettype wire

// ===== hw/epc_pkg.sv
// Constants for the encoder position counter
package epc_pkg;
  localparam int unsigned ADDR_W = 7;
  localparam logic [6:0] OFS_POSITION = 7'h39;
  localparam logic [6:0] OFS_STEP_FACTOR = 7'h3A;
  localparam logic [6:0] OFS_FLAGS = 7'h3B;
  localparam logic [6:0] OFS_LATCH = 7'h3C;
  localparam logic [31:0] RST_POSITION = 32'h0000_0000;
  localparam logic [31:0] RST_STEP_FACTOR = 32'h0001_0000;
  localparam logic [31:0] RST_LATCH = 32'h0000_0000;
  localparam logic RST_FLAG = 1'h0;
  localparam int unsigned FLAG_INDEX_BIT = 0;
  localparam int unsigned FRAC_W = 16;
  // Fraction moduli for binary and decimal scaling
  localparam logic [16:0] MOD_BINARY = 17'h10000;
  localparam logic [16:0] MOD_DECIMAL = 17'h02710;
  // Index sensitivity codes
  localparam logic [1:0] SENS_LEVEL = 2'h0;
  localparam logic [1:0] SENS_TO_ACTIVE = 2'h1;
  localparam logic [1:0] SENS_TO_INACTIVE = 2'h2;
  localparam logic [1:0] SENS_BOTH = 2'h3;
endpackage

// ===== test/epc_enc_model.sv
// Behavioural quadrature encoder with index channel
`timescale 1ns/1ps
`default_nettype none
module epc_enc_model (
  input wire logic i_clk_sys,
  output logic o_a,
  output logic o_b,
  output logic o_n
);
  int ph = 0;
  initial {o_a, o_b, o_n} = 3'h0;
  // Gray order 00,01,11,10 counts up; a move of 2 flips both lines at once
  task automatic move(input int d);
    @(negedge i_clk_sys);
    ph = (ph + d) & 3;
    {o_a, o_b} = {ph[1], ph[1] ^ ph[0]};
    // Four edges cover the two-stage sync and the update
    repeat (4) @(negedge i_clk_sys);
  endtask
  task automatic index(input logic v);
    @(negedge i_clk_sys);
    o_n = v;
    repeat (4) @(negedge i_clk_sys);
  endtask
endmodule
`default_nettype wire

// ===== test/encoder_position_counter_tb.sv
// Self-checking bench for the encoder position counter
`timescale 1ns/1ps
`default_nettype none
module encoder_position_counter_tb;
  logic clk = 1'b0;
  logic rstn, wr, rd, mwr;
  logic pa, pb, pn, ign;
  logic cont, once, clr, dec;
  logic [1:0] sens;
  logic [6:0] addr;
  logic [31:0] wdata;
  wire logic a, b, n;
  wire logic [31:0] rdata;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  always #12.5 clk = ~clk;
  epc_enc_model enc_u (.i_clk_sys(clk), .o_a(a), .o_b(b), .o_n(n));
  epc_counter dut_u (.i_clk_sys(clk), .i_resetn(rstn), .i_enc_a(a), .i_enc_b(b),
    .i_enc_n(n), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .i_mode_wr(mwr), .i_mode_pol_a(pa), .i_mode_pol_b(pb),
    .i_mode_pol_n(pn), .i_mode_index_ignore_quadrature(ign), .i_mode_latch_cont(cont),
    .i_mode_latch_once(once), .i_mode_index_sens(sens), .i_mode_clear_on_index(clr),
    .i_mode_sel_decimal(dec));
  // ****************************************
  // Bus tasks and expectations
  // ****************************************
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [6:0] ad, input logic [31:0] d);
    @(negedge clk);
    addr = ad;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [6:0] ad, input logic [31:0] e);
    @(negedge clk);
    addr = ad;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    cmp(rdata, e);
  endtask
  // Position after k up counts from a cleared fraction
  function automatic logic [31:0] acc(input int k, input logic [31:0] f, input bit d);
    int m = d ? 10000 : 65536;
    return $signed(f[31:16]) * k + (f[15:0] * k) / m;
  endfunction
  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] exp_pos;
    logic [15:0] fi;
    int d;
    {rstn, wr, rd, mwr} = 4'h0;
    {pa, pb, pn, ign} = 4'h3;
    {cont, once, clr, dec} = 4'h0;
    sens = 2'h1;
    addr = 7'h00;
    wdata = 32'h0000_0000;
    void'($urandom(64630));
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    rreg(7'h39, 32'h0);
    rreg(7'h3A, 32'h0001_0000);
    rreg(7'h3B, 32'h0);
    rreg(7'h3C, 32'h0);
    rreg(7'h00, 32'h0);
    wreg(7'h3C, 32'h1234_5678);
    rreg(7'h3C, 32'h0);
    wreg(7'h3A, 32'h8000_FFFF);
    rreg(7'h3A, 32'h8000_FFFF);
    wreg(7'h39, 32'h0);
    exp_pos = 32'h0;
    for (int i = 0; i < 24; i++) begin
      fi = 16'($urandom_range(1, 700));
      d = $urandom_range(0, 1) ? 1 : -1;
      // N stays inactive here, so no mode bit may disturb the count
      {mwr, pa, pb, ign, cont, once, clr, dec} = 8'($urandom);
      sens = 2'($urandom);
      wreg(7'h3A, {fi, 16'h0000});
      enc_u.move(d);
      exp_pos = exp_pos + (d > 0 ? {16'h0, fi} : -{16'h0, fi});
      rreg(7'h39, exp_pos);
    end
    {mwr, pa, pb, ign, cont, once, clr, dec} = 8'h10;
    sens = 2'h1;
    // Both lines flipping together must not count
    enc_u.move(2);
    rreg(7'h39, exp_pos);
    // Mid-run reset with A or B high: no phantom count may follow release
    if ({a, b} == 2'h0) begin
      enc_u.move(1);
    end
    rstn = 1'b0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    rreg(7'h39, 32'h0);
    rreg(7'h3A, 32'h0001_0000);
    rreg(7'h3B, 32'h0);
    exp_pos = 32'h0;
    wreg(7'h3A, 32'hFFFF_0000);
    enc_u.move(1);
    rreg(7'h39, exp_pos - 32'h1);
    for (int m = 0; m < 2; m++) begin
      dec = m[0];
      fi = m ? 16'h1388 : 16'h8000;
      wreg(7'h39, 32'h0);
      wreg(7'h3A, {15'h0, m[0], fi});
      repeat (3) enc_u.move(1);
      rreg(7'h39, acc(3, {15'h0, m[0], fi}, m[0]));
    end
    dec = 1'b0;
    cont = 1'b1;
    wreg(7'h39, 32'h0000_0123);
    enc_u.index(1'b1);
    rreg(7'h3C, 32'h0000_0123);
    wreg(7'h3B, 32'h0);
    rreg(7'h3B, 32'h1);
    wreg(7'h3B, 32'h1);
    rreg(7'h3B, 32'h0);
    enc_u.index(1'b0);
    clr = 1'b1;
    wreg(7'h39, 32'hFFFF_FF00);
    enc_u.index(1'b1);
    rreg(7'h3C, 32'hFFFF_FF00);
    rreg(7'h39, 32'h0);
    enc_u.index(1'b0);
    clr = 1'b0;
    cont = 1'b0;
    once = 1'b1;
    mwr = 1'b1;
    @(negedge clk);
    mwr = 1'b0;
    for (int k = 0; k < 2; k++) begin
      wreg(7'h39, 32'h55 + k);
      enc_u.index(1'b1);
      enc_u.index(1'b0);
      rreg(7'h3C, 32'h55);
    end
    once = 1'b0;
    for (int s = 0; s < 4; s++) begin
      sens = 2'(s);
      wreg(7'h3B, 32'h1);
      enc_u.index(1'b1);
      rreg(7'h3B, {31'h0, s != 2});
      wreg(7'h3B, 32'h1);
      enc_u.index(1'b0);
      rreg(7'h3B, {31'h0, s != 1});
    end
    sens = 2'h1;
    ign = 1'b0;
    pa = ~a;
    pb = b;
    wreg(7'h3B, 32'h1);
    enc_u.index(1'b1);
    enc_u.index(1'b0);
    rreg(7'h3B, 32'h0);
    pa = a;
    enc_u.index(1'b1);
    rreg(7'h3B, 32'h1);
    // Low-active N: the falling pin is the edge into the active state
    ign = 1'b1;
    pn = 1'b0;
    wreg(7'h3B, 32'h1);
    enc_u.index(1'b0);
    rreg(7'h3B, 32'h1);
    finish_test();
  end
endmodule
`default_nettype wire
